/* src/msi_top.sv */
// Modem status inputs of one serial channel with its register access.
module msi_top
   import msi_pkg::*;
(
   // Clock, reset, enable
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // Processor bus pins
   input wire logic CS_N,
   input wire logic IOR_N,
   input wire logic IOW_N,
   input wire logic [MSI_ADDR_W-1:0] ADDR,
   input wire logic [MSI_DATA_W-1:0] DATA_IN,
   output logic [MSI_DATA_W-1:0] DATA_OUT,
   output logic DATA_OE,
   // Modem handshake pins
   input wire logic CLEAR_TO_SEND_N,
   input wire logic DATA_SET_READY_N,
   input wire logic LINE_SIGNAL_DETECT_N,
   input wire logic PHONE_RINGING_N,
   // Serial receive line
   input wire logic RX_LINE,
   output logic RX_LINE_SYNC,
   // Interrupt
   output logic INT
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] modem_n;
   logic [2:0] strobe_n;
   logic [MSI_ADDR_W-1:0] addr_s;
   logic [MSI_DATA_W-1:0] data_s;
   logic rx_s;

   msi_sync #(.WIDTH(4), .RESET_VAL(4'hf)) u_sync_modem (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .d({LINE_SIGNAL_DETECT_N, PHONE_RINGING_N, DATA_SET_READY_N, CLEAR_TO_SEND_N}),
      .q(modem_n)
   );

   msi_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync_strobe (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .d({CS_N, IOW_N, IOR_N}),
      .q(strobe_n)
   );

   // Receive line flushes to idle high, so no false start bit
   localparam logic [MSI_ADDR_W+MSI_DATA_W:0] BUS_SYNC_RESET =
      {{(MSI_ADDR_W + MSI_DATA_W){1'b0}}, 1'b1};

   msi_sync #(.WIDTH(MSI_ADDR_W + MSI_DATA_W + 1), .RESET_VAL(BUS_SYNC_RESET)) u_sync_bus (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .d({ADDR, DATA_IN, RX_LINE}),
      .q({addr_s, data_s, rx_s})
   );

   logic cts_n_s;
   logic dsr_n_s;
   logic ring_n_s;
   logic lsd_n_s;

   assign cts_n_s = modem_n[0];
   assign dsr_n_s = modem_n[1];
   assign ring_n_s = modem_n[2];
   assign lsd_n_s = modem_n[3];

   // Strobes by name
   logic cs_n_s;
   logic iow_n_s;
   logic ior_n_s;

   assign cs_n_s = strobe_n[2];
   assign iow_n_s = strobe_n[1];
   assign ior_n_s = strobe_n[0];

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Strobe seen only while the chip is selected
   function automatic logic strobe_on(
      input logic sel_n,
      input logic str_n
   );
      return ~sel_n & ~str_n;
   endfunction

   function automatic logic addr_hit(
      input logic [MSI_ADDR_W-1:0] a,
      input logic [MSI_ADDR_W-1:0] target
   );
      return a == target;
   endfunction

   // ----------------------------------------------------------------
   // Bus strobe edges
   // ----------------------------------------------------------------
   logic rd_active;
   logic wr_active;
   logic rd_active_reg;
   logic wr_active_reg;
   logic rd_start;
   logic rd_end;
   logic wr_end;
   logic [MSI_ADDR_W-1:0] rd_addr_reg;
   logic [MSI_ADDR_W-1:0] wr_addr_reg;
   logic [MSI_DATA_W-1:0] wr_data_reg;

   // Synced strobe levels and their edges
   assign rd_active = strobe_on(cs_n_s, ior_n_s);
   assign wr_active = strobe_on(cs_n_s, iow_n_s);
   assign rd_start = rd_active & ~rd_active_reg;
   assign rd_end = rd_active_reg & ~rd_active;
   assign wr_end = wr_active_reg & ~wr_active;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         rd_active_reg <= 1'b0;
         wr_active_reg <= 1'b0;
      end else if (CLK_EN) begin
         rd_active_reg <= rd_active;
         wr_active_reg <= wr_active;
      end
   end

   // Address held from the start of a read to its end
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         rd_addr_reg <= '0;
      end else if (CLK_EN && rd_start) begin
         rd_addr_reg <= addr_s;
      end
   end

   // Write data and address tracked while the strobe is low
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         wr_addr_reg <= '0;
         wr_data_reg <= MSI_DATA_RESET;
      end else if (CLK_EN && wr_active) begin
         wr_addr_reg <= addr_s;
         wr_data_reg <= data_s;
      end
   end

   // ----------------------------------------------------------------
   // Change flags
   // ----------------------------------------------------------------
   logic clear_flags;
   logic cts_delta;
   logic dsr_delta;
   logic lsd_delta;
   logic ring_edge;

   // Flags clear once the status read completes
   assign clear_flags = rd_end && addr_hit(rd_addr_reg, MSI_ADDR_MODEM_STATUS);

   // Only flags the read returned are cleared, so a change seen mid-read stays
   logic clear_cts;
   logic clear_dsr;
   logic clear_lsd;
   logic clear_ring;

   assign clear_cts = clear_flags & DATA_OUT[MSI_BIT_CTS_DELTA];
   assign clear_dsr = clear_flags & DATA_OUT[MSI_BIT_DSR_DELTA];
   assign clear_lsd = clear_flags & DATA_OUT[MSI_BIT_LSD_DELTA];
   assign clear_ring = clear_flags & DATA_OUT[MSI_BIT_RING_EDGE];

   msi_change_flag #(.RISE_ONLY(1'b0)) u_cts_flag (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .level(cts_n_s),
      .clear(clear_cts),
      .flag(cts_delta)
   );

   msi_change_flag #(.RISE_ONLY(1'b0)) u_dsr_flag (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .level(dsr_n_s),
      .clear(clear_dsr),
      .flag(dsr_delta)
   );

   msi_change_flag #(.RISE_ONLY(1'b0)) u_lsd_flag (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .level(lsd_n_s),
      .clear(clear_lsd),
      .flag(lsd_delta)
   );

   msi_change_flag #(.RISE_ONLY(1'b1)) u_ring_flag (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .level(ring_n_s),
      .clear(clear_ring),
      .flag(ring_edge)
   );

   // ----------------------------------------------------------------
   // Interrupt enable register
   // ----------------------------------------------------------------
   logic [MSI_IE_W-1:0] int_enable_reg;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         int_enable_reg <= MSI_IE_RESET;
      end else if (CLK_EN && wr_end && addr_hit(wr_addr_reg, MSI_ADDR_INT_ENABLE)) begin
         int_enable_reg <= wr_data_reg[MSI_IE_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   logic [MSI_DATA_W-1:0] modem_status;

   always_comb begin
      modem_status = MSI_READ_ZERO;
      modem_status[MSI_BIT_CTS_DELTA] = cts_delta;
      modem_status[MSI_BIT_DSR_DELTA] = dsr_delta;
      modem_status[MSI_BIT_RING_EDGE] = ring_edge;
      modem_status[MSI_BIT_LSD_DELTA] = lsd_delta;
      modem_status[MSI_BIT_CTS] = ~cts_n_s;
      modem_status[MSI_BIT_DSR] = ~dsr_n_s;
      modem_status[MSI_BIT_RING] = ~ring_n_s;
      modem_status[MSI_BIT_LSD] = ~lsd_n_s;
   end

   function automatic logic [MSI_DATA_W-1:0] read_mux(
      input logic [MSI_ADDR_W-1:0] a,
      input logic [MSI_DATA_W-1:0] status,
      input logic [MSI_IE_W-1:0] ie
   );
      logic [MSI_DATA_W-1:0] r;
      r = MSI_READ_ZERO;
      if (addr_hit(a, MSI_ADDR_MODEM_STATUS)) begin
         r = status;
      end else if (addr_hit(a, MSI_ADDR_INT_ENABLE)) begin
         r[MSI_IE_W-1:0] = ie;
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Read data and bus drive
   // ----------------------------------------------------------------
   // Data captured at read start so the cleared flags never show mid-read
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         DATA_OUT <= MSI_DATA_RESET;
      end else if (CLK_EN && rd_start) begin
         DATA_OUT <= read_mux(addr_s, modem_status, int_enable_reg);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         DATA_OE <= 1'b0;
      end else if (CLK_EN) begin
         DATA_OE <= rd_active;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   logic any_change;

   assign any_change = cts_delta | dsr_delta | lsd_delta | ring_edge;

   // Follows the flags one cycle later

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         INT <= 1'b0;
      end else if (CLK_EN) begin
         INT <= int_enable_reg[MSI_BIT_IE_MODEM] & any_change;
      end
   end

   // ----------------------------------------------------------------
   // Receive line passes straight on
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         RX_LINE_SYNC <= 1'b1;
      end else if (CLK_EN) begin
         RX_LINE_SYNC <= rx_s;
      end
   end
endmodule

/* src/msi_pkg.sv */
// Constants shared by the modem status input logic.
// Notes on behaviour
// - While the master reset is active every register is cleared, except the modem pin, strobe, receive line and change-flag history stages, which reset high.
// - Status bit 4 always reads as the inverse of the clear_to_send_n level.
// - Bit 0 is set when clear_to_send_n has changed since the last status read.
// - A clear-to-send change raises the channel interrupt when modem interrupts are enabled.
// - Status bit 5 always reads as the inverse of the data_set_ready_n level.
// - Bit 1 is set when data_set_ready_n has changed since the last status read.
// - A data-set-ready change raises the channel interrupt when modem interrupts are enabled.
// - Status bit 7 always reads as the inverse of the line_signal_detect_n level.
// - Bit 3 is set when line_signal_detect_n has changed since the last status read.
// - The line detect input is status only and never gates the receive line.
// - A line-detect change raises the channel interrupt when modem interrupts are enabled.
// - Status bit 6 always reads as the inverse of the phone_ringing_n level.
// - Bit 2 is set only by a low-to-high change of phone_ringing_n since the last read.
// - Only that low-to-high ringing change raises the interrupt, when enabled.
package msi_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [2:0] MSI_ADDR_INT_ENABLE = 3'h1;
   localparam logic [2:0] MSI_ADDR_MODEM_STATUS = 3'h6;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MSI_BIT_CTS_DELTA = 0;
   localparam int MSI_BIT_DSR_DELTA = 1;
   localparam int MSI_BIT_RING_EDGE = 2;
   localparam int MSI_BIT_LSD_DELTA = 3;
   localparam int MSI_BIT_CTS = 4;
   localparam int MSI_BIT_DSR = 5;
   localparam int MSI_BIT_RING = 6;
   localparam int MSI_BIT_LSD = 7;
   localparam int MSI_BIT_IE_MODEM = 3;
   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int MSI_DATA_W = 8;
   localparam int MSI_ADDR_W = 3;
   localparam int MSI_IE_W = 4;
   localparam logic [MSI_IE_W-1:0] MSI_IE_RESET = 4'h0;
   localparam logic [MSI_DATA_W-1:0] MSI_DATA_RESET = 8'h00;
   localparam logic [MSI_DATA_W-1:0] MSI_READ_ZERO = 8'h00;
endpackage

/* src/msi_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
module msi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= RESET_VAL;
         q <= RESET_VAL;
      end else if (ce) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

/* src/msi_change_flag.sv */
// Sticky change flag for one synchronised modem input.
module msi_change_flag #(
   parameter bit RISE_ONLY = 1'b0
) (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Input level and clear
   input wire logic level,
   input wire logic clear,
   // Flag
   output logic flag
);
   logic prev_reg;
   logic event_now;

   // Inactive pins sit high, so history starts high
   assign event_now = RISE_ONLY ? (level & ~prev_reg) : (level ^ prev_reg);

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_reg <= 1'b1;
      end else if (ce) begin
         prev_reg <= level;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (ce) begin
         if (event_now) begin
            flag <= 1'b1;
         end else if (clear) begin
            flag <= 1'b0;
         end
      end
   end
endmodule

/* bench/msi_assertions.sv */
// Concurrent checks on the modem status input block.
module msi_chk
   import msi_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Processor bus
   input wire logic CS_N,
   input wire logic IOW_N,
   input wire logic [MSI_ADDR_W-1:0] ADDR,
   input wire logic [MSI_DATA_W-1:0] DATA_IN,
   input wire logic [MSI_DATA_W-1:0] DATA_OUT,
   input wire logic DATA_OE,
   // Modem and serial pins
   input wire logic CLEAR_TO_SEND_N,
   input wire logic DATA_SET_READY_N,
   input wire logic LINE_SIGNAL_DETECT_N,
   input wire logic PHONE_RINGING_N,
   input wire logic RX_LINE,
   input wire logic RX_LINE_SYNC,
   input wire logic INT
);
   logic [3:0] pins;
   logic [3:0] pins_d_reg;
   logic [3:0] quiet_reg;
   logic ie_on_reg;
   logic rd6_reg;
   logic oe_d_reg;
   assign pins = {LINE_SIGNAL_DETECT_N, PHONE_RINGING_N, DATA_SET_READY_N, CLEAR_TO_SEND_N};
   // Cycles since the last modem pin change, saturating
   always_ff @(posedge SYS_CLK) begin
      pins_d_reg <= pins;
      if (SYS_RST) begin
         quiet_reg <= 4'h0;
      end else begin
         quiet_reg <= (pins != pins_d_reg) ? 4'h0 : (quiet_reg == 4'hf) ? 4'hf : quiet_reg + 4'h1;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ie_on_reg <= 1'b0;
      end else if (!CS_N && !IOW_N && ADDR == MSI_ADDR_INT_ENABLE) begin
         ie_on_reg <= DATA_IN[MSI_BIT_IE_MODEM];
      end
   end
   always_ff @(posedge SYS_CLK) begin
      oe_d_reg <= DATA_OE;
      if (DATA_OE && !oe_d_reg) begin
         rd6_reg <= (ADDR == MSI_ADDR_MODEM_STATUS);
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   a_reset_clears: assert property (disable iff (1'b0)
      SYS_RST |=> !INT && !DATA_OE && DATA_OUT == 8'h00) else $error("reset left outputs set");
   a_level_bits: assert property (
      $rose(DATA_OE) && ADDR == MSI_ADDR_MODEM_STATUS && quiet_reg > 4'h5
      |-> DATA_OUT[7:4] == ~pins) else $error("status levels wrong");
   a_cts_int: assert property (
      ie_on_reg && $changed(CLEAR_TO_SEND_N) |-> ##[3:5] INT) else $error("no cts interrupt");
   a_dsr_int: assert property (
      ie_on_reg && $changed(DATA_SET_READY_N) |-> ##[3:5] INT) else $error("no dsr interrupt");
   a_lsd_int: assert property (
      ie_on_reg && $changed(LINE_SIGNAL_DETECT_N) |-> ##[3:5] INT) else $error("no lsd interrupt");
   a_ring_rise: assert property (
      ie_on_reg && $rose(PHONE_RINGING_N) |-> ##[3:5] INT) else $error("no ring interrupt");
   a_ring_fall: assert property (
      ie_on_reg && $fell(PHONE_RINGING_N) && !INT && quiet_reg > 4'h5 |=> !INT [*6])
      else $error("ring start raised interrupt");
   a_read_clears: assert property (
      $fell(DATA_OE) && rd6_reg && quiet_reg > 4'h9 |=> !INT) else $error("read left interrupt");
   a_rx_follows: assert property (
      RX_LINE_SYNC == $past(RX_LINE, 3)) else $error("receive line altered");
   c_status_read: cover property ($rose(DATA_OE) && ADDR == MSI_ADDR_MODEM_STATUS);
   c_int_rise: cover property ($rose(INT));
   c_ring_end: cover property ($rose(PHONE_RINGING_N));
endmodule

bind msi_top msi_chk u_msi_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CS_N(CS_N),
   .IOW_N(IOW_N), .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
   .CLEAR_TO_SEND_N(CLEAR_TO_SEND_N), .DATA_SET_READY_N(DATA_SET_READY_N),
   .LINE_SIGNAL_DETECT_N(LINE_SIGNAL_DETECT_N), .PHONE_RINGING_N(PHONE_RINGING_N),
   .RX_LINE(RX_LINE), .RX_LINE_SYNC(RX_LINE_SYNC), .INT(INT));

/* bench/msi_modem_model.sv */
// Behavioural modem driving the four handshake lines.
module msi_modem_model (
   // Clock
   input wire logic clk,
   // Requested levels, in status flag order
   input wire logic [3:0] want,
   // Handshake lines, idle high
   output logic cts_n,
   output logic dsr_n,
   output logic ring_n,
   output logic lsd_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] line_reg = 4'hf;
   always @(posedge clk) line_reg <= want;
   assign cts_n = line_reg[0];
   assign dsr_n = line_reg[1];
   assign ring_n = line_reg[2];
   assign lsd_n = line_reg[3];
endmodule

/* bench/modem_status_inputs_tb_top.sv */
// Self-checking bench for the modem status input block.
module modem_status_inputs_tb_top import msi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, cs_n = 1'b1, ior_n = 1'b1, iow_n = 1'b1, rx = 1'b1;
   logic [MSI_ADDR_W-1:0] addr = '0;
   logic [MSI_DATA_W-1:0] din = '0, dout, fl;
   logic oe, intr, rx_sync, cts_n, dsr_n, lsd_n, ring_n;
   logic [3:0] want = 4'hf;
   int error_cnt = 0, comparisons = 0;
   always #2.5 clk = ~clk;
   msi_modem_model modem (.clk(clk), .want(want), .cts_n(cts_n), .dsr_n(dsr_n),
      .ring_n(ring_n), .lsd_n(lsd_n));
   msi_top dut (.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1), .CS_N(cs_n), .IOR_N(ior_n),
      .IOW_N(iow_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
      .CLEAR_TO_SEND_N(cts_n), .DATA_SET_READY_N(dsr_n), .LINE_SIGNAL_DETECT_N(lsd_n),
      .PHONE_RINGING_N(ring_n), .RX_LINE(rx), .RX_LINE_SYNC(rx_sync), .INT(intr));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_oe(input logic lvl);
      for (int n = 0; n < 20 && oe !== lvl; n++) @(negedge clk);
      if (oe !== lvl) begin
         error_cnt++;
         $display("wrong value at %0t: bus answer missing", $time);
      end
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      cs_n <= 1'b0;
      ior_n <= 1'b0;
      addr <= a;
      wait_oe(1'b1);
      chk(dout, exp);
      @(posedge clk);
      cs_n <= 1'b1;
      ior_n <= 1'b1;
      wait_oe(1'b0);
      repeat (3) @(negedge clk);
   endtask
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      cs_n <= 1'b0;
      iow_n <= 1'b0;
      addr <= a;
      din <= d;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      iow_n <= 1'b1;
      repeat (4) @(negedge clk);
   endtask
   task automatic set_pins(input logic [3:0] v);
      @(posedge clk);
      want <= v;
      repeat (8) @(negedge clk);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_chk(MSI_ADDR_MODEM_STATUS, 8'h00);
      rd_chk(MSI_ADDR_INT_ENABLE, 8'h00);
      bus_wr(MSI_ADDR_INT_ENABLE, 8'h08);
      rd_chk(3'h2, 8'h00);
      rd_chk(MSI_ADDR_INT_ENABLE, 8'h08);
      for (int p = 0; p < 4; p++) begin
         fl = (p == MSI_BIT_RING_EDGE) ? 8'h00 : 8'h01 << p;
         set_pins(want & ~(4'h1 << p));
         chk({7'h00, intr}, {7'h00, fl != 8'h00});
         rd_chk(MSI_ADDR_MODEM_STATUS, {~want, fl[3:0]});
         chk({7'h00, intr}, 8'h00);
         rd_chk(MSI_ADDR_MODEM_STATUS, {~want, 4'h0});
         set_pins(4'hf);
         chk({7'h00, intr}, 8'h01);
         rd_chk(MSI_ADDR_MODEM_STATUS, {4'h0, 4'h1 << p});
      end
      set_pins(4'he);
      set_pins(4'hf);
      rd_chk(MSI_ADDR_MODEM_STATUS, 8'h01);
      bus_wr(MSI_ADDR_INT_ENABLE, 8'h00);
      set_pins(4'hd);
      chk({7'h00, intr}, 8'h00);
      rd_chk(MSI_ADDR_MODEM_STATUS, 8'h22);
      set_pins(4'h5);
      @(posedge clk);
      rx <= 1'b0;
      repeat (4) @(negedge clk);
      chk({7'h00, rx_sync}, 8'h00);
      @(posedge clk);
      rx <= 1'b1;
      repeat (4) @(negedge clk);
      chk({7'h00, rx_sync}, 8'h01);
      bus_wr(MSI_ADDR_INT_ENABLE, 8'h08);
      set_pins(4'he);
      set_pins(4'hf);
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({7'h00, intr}, 8'h00);
      rd_chk(MSI_ADDR_INT_ENABLE, 8'h00);
      rd_chk(MSI_ADDR_MODEM_STATUS, 8'h00);
      report_and_stop;
   end
   initial begin
      #50us;
      error_cnt++;
      $display("wrong value at %0t: run hung", $time);
      report_and_stop;
   end
endmodule
